// ==== rtl/cpu_flags_pkg.sv ====
package cpu_flags_pkg;
	localparam int DW = 8;
	localparam int AW = 4;

	// Register byte addresses
	localparam logic [AW-1:0] ADDR_OPERAND_A  = 4'h0;
	localparam logic [AW-1:0] ADDR_OPERAND_B  = 4'h1;
	localparam logic [AW-1:0] ADDR_COMMAND    = 4'h2;
	localparam logic [AW-1:0] ADDR_RESULT_LO  = 4'h4;
	localparam logic [AW-1:0] ADDR_RESULT_HI  = 4'h5;
	localparam logic [AW-1:0] ADDR_STACK_PTR  = 4'h6;
	localparam logic [AW-1:0] ADDR_STACK_TOP  = 4'h7;
	localparam logic [AW-1:0] ADDR_PORT_DIR   = 4'h8;
	localparam logic [AW-1:0] ADDR_CLOCK_MODE = 4'h9;
	localparam logic [AW-1:0] ADDR_BOOT_STAT  = 4'ha;
	localparam logic [AW-1:0] ADDR_BOOT_RX    = 4'hb;

	// Processor status word bit positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_I = 2;
	localparam int FLG_D = 3;
	localparam int FLG_B = 4;
	localparam int FLG_T = 5;
	localparam int FLG_V = 6;
	localparam int FLG_N = 7;
	localparam logic [DW-1:0] PSW_RESET = 8'h04;
	localparam logic [DW-1:0] SP_RESET  = 8'hff;

	// Boot status bit positions
	localparam int BST_ACTIVE = 0;
	localparam int BST_SCLK   = 1;
	localparam int BST_RXV    = 2;
	localparam int BST_BUSY   = 3;

	typedef enum logic [3:0] {
		OP_NONE     = 4'h0,
		OP_ADDC     = 4'h1,
		OP_SUBB     = 4'h2,
		OP_PRODUCT  = 4'h3,
		OP_QUOTIENT = 4'h4,
		OP_PUSH_PSW = 4'h5,
		OP_PULL_PSW = 4'h6,
		OP_SET_C    = 4'h7,
		OP_CLR_C    = 4'h8,
		OP_SET_D    = 4'h9,
		OP_CLR_D    = 4'ha,
		OP_INCR     = 4'hb
	} opcode_e;

	// Instruction lengths in internal clock cycles
	localparam logic [4:0] CYC_ARITH    = 5'h02;
	localparam logic [4:0] CYC_PRODUCT  = 5'h08;
	localparam logic [4:0] CYC_QUOTIENT = 5'h10;
	localparam logic [4:0] CYC_PUSH     = 5'h03;
	localparam logic [4:0] CYC_PULL     = 5'h04;
	localparam logic [4:0] CYC_SHORT    = 5'h02;

	// Internal clock source selection and divide limits
	localparam logic [1:0] CLK_HIGH       = 2'h0;
	localparam logic [1:0] CLK_MID        = 2'h1;
	localparam logic [1:0] CLK_LOW        = 2'h2;
	localparam logic [1:0] CLK_MODE_RESET = CLK_MID;
	localparam logic [2:0] DIV_HIGH       = 3'h1;
	localparam logic [2:0] DIV_MID        = 3'h7;
	localparam logic [2:0] DIV_LOW        = 3'h1;

	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_ADJ = 4'h6;

	// Boot serial link timing
	localparam int         CLK_NS     = 20;
	localparam int         BIT_NS     = 8680;
	localparam logic [8:0] BIT_CYC    = 9'(BIT_NS / CLK_NS);
	localparam logic [8:0] HALF_BIT   = 9'(BIT_NS / CLK_NS / 2);
	localparam logic [3:0] FRAME_BITS = 4'ha;

	typedef enum logic [1:0] {
		EX_IDLE = 2'b01,
		EX_RUN  = 2'b10
	} exec_e;

	typedef enum logic [2:0] {
		SER_IDLE = 3'b001,
		SER_RX   = 3'b010,
		SER_TX   = 3'b100
	} ser_e;

	typedef struct packed {
		logic          wr;
		logic          rd;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} bus_req_s;

	typedef struct packed {
		exec_e         ex;
		opcode_e       op;
		logic [4:0]    tick_cnt;
		logic [2:0]    div_cnt;
		logic          main_q;
		logic          sub_q;
		logic [DW-1:0] opa;
		logic [DW-1:0] opb;
		logic [DW-1:0] psw;
		logic [DW-1:0] res_lo;
		logic [DW-1:0] res_hi;
		logic [DW-1:0] sp;
		logic [DW-1:0] port_dir;
		logic [DW-1:0] rd_data;
		logic [1:0]    clk_mode;
		logic          strap_done;
		logic          boot_act;
		logic          sclk_err;
		logic          rx_valid;
		ser_e          ser;
		logic [8:0]    baud_cnt;
		logic [3:0]    bit_cnt;
		logic [9:0]    shreg;
		logic [DW-1:0] rx_byte;
		logic          ser_out;
		logic          busy;
	} core_s;

	localparam core_s CORE_RESET = '{ex: EX_IDLE, op: OP_NONE, psw: PSW_RESET, sp: SP_RESET,
		clk_mode: CLK_MODE_RESET, ser: SER_IDLE, ser_out: 1'b1, default: '0};
endpackage

// ==== rtl/bcd_digit.sv ====
`timescale 1ns/1ns
`default_nettype none
module bcd_digit
	import cpu_flags_pkg::*;
(
	input  wire logic [3:0] a,
	input  wire logic [3:0] b,
	input  wire logic       ci,
	input  wire logic       sub,
	input  wire logic       dec,
	output logic [3:0]      s,
	output logic            co
);
	logic [4:0] t;
	logic [3:0] bx;
	logic       adj;

	always_comb begin
		bx  = sub ? ~b : b;
		t   = {1'b0, a} + {1'b0, bx} + {4'h0, ci};
		// Subtract corrects on a digit borrow, add on a digit above nine
		adj = dec && (sub ? !t[4] : (t[4] || (t[3:0] > BCD_MAX)));
		co  = (dec && !sub) ? adj : t[4];
		s   = sub ? (t[3:0] - (adj ? BCD_ADJ : 4'h0)) : (t[3:0] + (adj ? BCD_ADJ : 4'h0));
	end
endmodule
`default_nettype wire

// ==== rtl/cpu_status_flags_decimal_alu.sv ====
`timescale 1ns/1ns
`default_nettype none
// Function
// - After reset every status flag is undefined except the interrupt mask, which is one.
// - Pushing the status word stores it on the stack, readable just above the stack pointer.
// - With the decimal flag set only add and subtract produce decimal-corrected results.
// - After a decimal add or subtract the sign, overflow and zero flags mean nothing.
// - A decimal carry sets the carry flag and a decimal borrow clears it.
// - Product and quotient ignore the index mode and decimal flags.
// - Product and quotient leave the whole status word unchanged.
// - Port direction registers are write-only and read back nothing meaningful.
// - An instruction lasts its cycle count times the internal clock period.
// - The internal clock is 2 or 8 main oscillator periods, or 2 sub oscillator periods.
// - Boot mode 2 receives on serial in, drives serial out and busy; shift clock is held low.
// - Boot mode 2 uses asynchronous framing with no shared clock.
module cpu_status_flags_decimal_alu
	import cpu_flags_pkg::*;
#(
	parameter int STACK_DEPTH = 16
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire bus_req_s      bus,
	output logic [DW-1:0]      rd_data,
	input  wire logic          main_osc_input,
	input  wire logic          sub_osc_input,
	input  wire logic          boot_select_pin,
	input  wire logic          serial_in,
	input  wire logic          serial_shift_clock,
	output logic               serial_out,
	output logic               busy_out,
	output logic [DW-1:0]      port_dir
);
	localparam int SPW = $clog2(STACK_DEPTH);

	logic [1:0]    rst_ff;
	logic          rst_n;
	core_s         st_q;
	core_s         st_d;
	logic [DW-1:0] stack [STACK_DEPTH];
	logic          mem_we;
	logic [SPW-1:0] sp_idx;
	logic [SPW-1:0] sp_inc;
	logic [DW-1:0] sp_up;
	logic          main_rise;
	logic          sub_rise;
	logic          osc_edge;
	logic [2:0]    div_lim;
	logic          tick;
	logic          start;
	logic          commit;
	logic          is_sub;
	logic          dec_on;
	logic [DW-1:0] alu_b;
	logic          alu_ci;
	logic [DW-1:0] alu_r;
	logic          c_lo;
	logic          c_hi;
	logic          alu_v;
	logic [15:0]   prod;

	function automatic logic [4:0] op_cycles(input opcode_e o);
		case (o)
			OP_ADDC, OP_SUBB: return CYC_ARITH;
			OP_PRODUCT:       return CYC_PRODUCT;
			OP_QUOTIENT:      return CYC_QUOTIENT;
			OP_PUSH_PSW:      return CYC_PUSH;
			OP_PULL_PSW:      return CYC_PULL;
			default:          return CYC_SHORT;
		endcase
	endfunction

	// Short external pulses are stretched here so the core always sees a full reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_ff <= 2'b00;
		end else begin
			rst_ff <= {rst_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_ff[1];

	bcd_digit u_digit_lo (
		.a   (st_q.opa[3:0]),
		.b   (alu_b[3:0]),
		.ci  (alu_ci),
		.sub (is_sub),
		.dec (dec_on),
		.s   (alu_r[3:0]),
		.co  (c_lo)
	);

	bcd_digit u_digit_hi (
		.a   (st_q.opa[7:4]),
		.b   (alu_b[7:4]),
		.ci  (c_lo),
		.sub (is_sub),
		.dec (dec_on),
		.s   (alu_r[7:4]),
		.co  (c_hi)
	);

	always_comb begin
		sp_idx    = st_q.sp[SPW-1:0];
		sp_up     = st_q.sp + 8'h01;
		sp_inc    = sp_up[SPW-1:0];
		is_sub    = (st_q.op == OP_SUBB);
		dec_on    = st_q.psw[FLG_D] && (st_q.op == OP_ADDC || is_sub);
		alu_b     = (st_q.op == OP_INCR) ? 8'h01 : st_q.opb;
		alu_ci    = (st_q.op == OP_INCR) ? 1'b0 : st_q.psw[FLG_C];
		alu_v     = (st_q.opa[7] == (alu_b[7] ^ is_sub)) && (alu_r[7] != st_q.opa[7]);
		prod      = {8'h00, st_q.opa} * {8'h00, st_q.opb};
		main_rise = main_osc_input && !st_q.main_q;
		sub_rise  = sub_osc_input && !st_q.sub_q;
		osc_edge  = (st_q.clk_mode == CLK_LOW) ? sub_rise : main_rise;
		case (st_q.clk_mode)
			CLK_MID: div_lim = DIV_MID;
			CLK_LOW: div_lim = DIV_LOW;
			default: div_lim = DIV_HIGH;
		endcase
		tick = osc_edge && (st_q.div_cnt >= div_lim);
	end

	always_comb begin
		st_d        = st_q;
		mem_we      = 1'b0;
		start       = 1'b0;
		commit      = 1'b0;
		st_d.rd_data = '0;
		st_d.main_q = main_osc_input;
		st_d.sub_q  = sub_osc_input;
		if (osc_edge) begin
			st_d.div_cnt = tick ? 3'h0 : st_q.div_cnt + 3'h1;
		end

		// Strap is caught once, in the first cycle after reset release
		if (!st_q.strap_done) begin
			st_d.strap_done = 1'b1;
			st_d.boot_act   = boot_select_pin;
		end

		case (st_q.ex)
			EX_IDLE: begin
				if (bus.wr && bus.addr == ADDR_COMMAND) begin
					start         = 1'b1;
					st_d.ex       = EX_RUN;
					st_d.op       = opcode_e'(bus.wdata[3:0]);
					st_d.tick_cnt = 5'h00;
				end
			end
			EX_RUN: begin
				if (tick) begin
					if (st_q.tick_cnt == op_cycles(st_q.op) - 5'h01) begin
						commit  = 1'b1;
						st_d.ex = EX_IDLE;
					end else begin
						st_d.tick_cnt = st_q.tick_cnt + 5'h01;
					end
				end
			end
			default: st_d.ex = EX_IDLE;
		endcase

		if (commit) begin
			case (st_q.op)
				OP_ADDC, OP_SUBB: begin
					st_d.res_lo       = alu_r;
					st_d.psw[FLG_C]   = c_hi;
					// Set from the result after decimal correction; meaningless in decimal mode
					st_d.psw[FLG_Z]   = (alu_r == 8'h00);
					st_d.psw[FLG_N]   = alu_r[7];
					st_d.psw[FLG_V]   = alu_v;
				end
				OP_INCR: begin
					st_d.res_lo     = alu_r;
					st_d.psw[FLG_Z] = (alu_r == 8'h00);
					st_d.psw[FLG_N] = alu_r[7];
				end
				// No flag is touched and neither mode flag is looked at
				OP_PRODUCT: begin
					st_d.res_lo = prod[7:0];
					st_d.res_hi = prod[15:8];
				end
				OP_QUOTIENT: begin
					if (st_q.opb != 8'h00) begin
						st_d.res_lo = st_q.opa / st_q.opb;
						st_d.res_hi = st_q.opa % st_q.opb;
					end else begin
						st_d.res_lo = 8'hff;
						st_d.res_hi = st_q.opa;
					end
				end
				OP_PUSH_PSW: begin
					mem_we  = 1'b1;
					st_d.sp = st_q.sp - 8'h01;
				end
				OP_PULL_PSW: begin
					st_d.psw = stack[sp_inc];
					st_d.sp  = sp_up;
				end
				OP_SET_C: st_d.psw[FLG_C] = 1'b1;
				OP_CLR_C: st_d.psw[FLG_C] = 1'b0;
				OP_SET_D: st_d.psw[FLG_D] = 1'b1;
				OP_CLR_D: st_d.psw[FLG_D] = 1'b0;
				default: ;
			endcase
		end

		if (bus.wr) begin
			case (bus.addr)
				ADDR_OPERAND_A: st_d.opa = bus.wdata;
				ADDR_OPERAND_B: st_d.opb = bus.wdata;
				ADDR_STACK_PTR: st_d.sp = bus.wdata;
				ADDR_PORT_DIR:  st_d.port_dir = bus.wdata;
				ADDR_CLOCK_MODE: begin
					st_d.clk_mode = bus.wdata[1:0];
					st_d.div_cnt  = 3'h0;
				end
				ADDR_BOOT_STAT: begin
					if (bus.wdata[BST_SCLK]) begin
						st_d.sclk_err = 1'b0;
					end
				end
				default: ;
			endcase
		end

		if (bus.rd) begin
			case (bus.addr)
				ADDR_OPERAND_A:  st_d.rd_data = st_q.opa;
				ADDR_OPERAND_B:  st_d.rd_data = st_q.opb;
				ADDR_COMMAND:    st_d.rd_data = {7'h00, st_q.ex == EX_RUN};
				ADDR_RESULT_LO:  st_d.rd_data = st_q.res_lo;
				ADDR_RESULT_HI:  st_d.rd_data = st_q.res_hi;
				ADDR_STACK_PTR:  st_d.rd_data = st_q.sp;
				ADDR_STACK_TOP:  st_d.rd_data = stack[sp_inc];
				ADDR_CLOCK_MODE: st_d.rd_data = {6'h00, st_q.clk_mode};
				ADDR_BOOT_STAT:  st_d.rd_data = {4'h0, st_q.busy, st_q.rx_valid,
					st_q.sclk_err, st_q.boot_act};
				ADDR_BOOT_RX: begin
					st_d.rd_data  = st_q.rx_byte;
					st_d.rx_valid = 1'b0;
				end
				// Direction registers and unmapped addresses read zero
				default: st_d.rd_data = '0;
			endcase
		end

		// Sets follow the clears so an event in a clear cycle survives
		if (st_q.boot_act && serial_shift_clock) begin
			st_d.sclk_err = 1'b1;
		end

		// Start bit is not re-checked at mid bit; a glitch costs one echoed frame
		case (st_q.ser)
			SER_IDLE: begin
				st_d.busy    = 1'b0;
				st_d.ser_out = 1'b1;
				if (st_q.boot_act && !serial_in) begin
					st_d.ser      = SER_RX;
					st_d.baud_cnt = HALF_BIT;
					st_d.bit_cnt  = 4'h0;
					st_d.busy     = 1'b1;
				end
			end
			SER_RX: begin
				if (st_q.baud_cnt == 9'h000) begin
					st_d.baud_cnt = BIT_CYC - 9'h001;
					st_d.shreg    = {serial_in, st_q.shreg[9:1]};
					st_d.bit_cnt  = st_q.bit_cnt + 4'h1;
					if (st_q.bit_cnt == FRAME_BITS - 4'h1) begin
						st_d.rx_byte  = st_q.shreg[9:2];
						st_d.rx_valid = 1'b1;
						st_d.ser      = SER_TX;
						st_d.shreg    = {1'b1, st_q.shreg[9:2], 1'b0};
						st_d.bit_cnt  = 4'h0;
						st_d.baud_cnt = 9'h000;
					end
				end else begin
					st_d.baud_cnt = st_q.baud_cnt - 9'h001;
				end
			end
			SER_TX: begin
				if (st_q.baud_cnt == 9'h000) begin
					if (st_q.bit_cnt == FRAME_BITS) begin
						st_d.ser  = SER_IDLE;
						st_d.busy = 1'b0;
					end else begin
						st_d.ser_out  = st_q.shreg[0];
						st_d.shreg    = {1'b1, st_q.shreg[9:1]};
						st_d.bit_cnt  = st_q.bit_cnt + 4'h1;
						st_d.baud_cnt = BIT_CYC - 9'h001;
					end
				end else begin
					st_d.baud_cnt = st_q.baud_cnt - 9'h001;
				end
			end
			default: st_d.ser = SER_IDLE;
		endcase
	end

	// Interrupt mask forced, remaining flags take a fixed but unpromised value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= CORE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Stack memory holds no reset; only the pointer is defined
	always_ff @(posedge clk) begin
		if (mem_we) begin
			stack[sp_idx] <= st_q.psw;
		end
	end

	assign rd_data    = st_q.rd_data;
	assign serial_out = st_q.ser_out;
	assign busy_out   = st_q.busy;
	assign port_dir   = st_q.port_dir;

	logic [4:0] run_ticks;
	logic [2:0] edge_cnt;
	logic       bcd_ok;
	logic [8:0] dec_sum;

	always_comb begin
		bcd_ok  = (st_q.opa[7:4] <= BCD_MAX) && (st_q.opa[3:0] <= BCD_MAX)
			&& (st_q.opb[7:4] <= BCD_MAX) && (st_q.opb[3:0] <= BCD_MAX);
		dec_sum = ({5'h00, st_q.opa[7:4]} * 9'h00a) + {5'h00, st_q.opa[3:0]}
			+ ({5'h00, st_q.opb[7:4]} * 9'h00a) + {5'h00, st_q.opb[3:0]}
			+ {8'h00, st_q.psw[FLG_C]};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_ticks <= 5'h00;
			edge_cnt  <= 3'h0;
		end else begin
			if (start) begin
				run_ticks <= 5'h00;
			end else if (st_q.ex == EX_RUN && tick) begin
				run_ticks <= run_ticks + 5'h01;
			end
			if (tick || (bus.wr && bus.addr == ADDR_CLOCK_MODE)) begin
				edge_cnt <= 3'h0;
			end else if (main_rise) begin
				edge_cnt <= edge_cnt + 3'h1;
			end
		end
	end

	chk_reset_imask: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(rst_n) |-> st_q.psw[FLG_I])
		else $error("interrupt mask not set after reset");

	chk_push_word: assert property (@(posedge clk) disable iff (!rst_n)
		commit && st_q.op == OP_PUSH_PSW |=> stack[sp_inc] == $past(st_q.psw))
		else $error("pushed status word not found above stack pointer");

	chk_dec_digits: assert property (@(posedge clk) disable iff (!rst_n)
		commit && st_q.op == OP_ADDC && st_q.psw[FLG_D] && bcd_ok
		|=> st_q.res_lo[7:4] <= BCD_MAX && st_q.res_lo[3:0] <= BCD_MAX)
		else $error("decimal add left a digit above nine");

	chk_dec_carry: assert property (@(posedge clk) disable iff (!rst_n)
		commit && st_q.op == OP_ADDC && st_q.psw[FLG_D] && bcd_ok
		|=> st_q.psw[FLG_C] == ($past(dec_sum) > 9'h063))
		else $error("decimal carry flag wrong");

	chk_muldiv_psw: assert property (@(posedge clk) disable iff (!rst_n)
		commit && (st_q.op == OP_PRODUCT || st_q.op == OP_QUOTIENT)
		|=> $stable(st_q.psw))
		else $error("product or quotient changed the status word");

	chk_product_mode: assert property (@(posedge clk) disable iff (!rst_n)
		commit && st_q.op == OP_PRODUCT
		|=> {st_q.res_hi, st_q.res_lo} == $past(prod))
		else $error("product result wrong");

	chk_dir_noread: assert property (@(posedge clk) disable iff (!rst_n)
		bus.rd && bus.addr == ADDR_PORT_DIR |=> rd_data == 8'h00)
		else $error("direction register read back data");

	chk_op_length: assert property (@(posedge clk) disable iff (!rst_n)
		commit |-> tick && (run_ticks + 5'h01 == op_cycles(st_q.op)))
		else $error("instruction length wrong");

	chk_tick_mid: assert property (@(posedge clk) disable iff (!rst_n)
		tick && st_q.clk_mode == CLK_MID |-> main_rise && edge_cnt == 3'h7)
		else $error("middle speed tick not every eighth edge");

	chk_boot_busy: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.boot_act && st_q.ser == SER_IDLE && !serial_in |=> busy_out ##1 busy_out)
		else $error("busy not raised on start bit");
endmodule
`default_nettype wire

// ==== tb/boot_programmer.sv ====
`timescale 1ns/1ns
`default_nettype none
module boot_programmer
	import cpu_flags_pkg::*;
(
	input  wire logic clk,
	input  wire logic serial_out,
	output logic      serial_in,
	output logic      serial_shift_clock,
	output logic      boot_select_pin
);
	initial begin
		serial_in          = 1'b1;
		serial_shift_clock = 1'b0;
		boot_select_pin    = 1'b0;
	end

	// Strap goes up last so the other entry inputs are already settled
	task automatic enter_boot();
		@(posedge clk);
		serial_in <= 1'b1;
		serial_shift_clock <= 1'b0;
		@(posedge clk);
		boot_select_pin <= 1'b1;
	endtask

	// Deliberate fault: the shift clock should stay low in this mode
	task automatic sclk_glitch();
		@(posedge clk);
		serial_shift_clock <= 1'b1;
		@(posedge clk);
		serial_shift_clock <= 1'b0;
	endtask

	// No shared clock, so each bit is simply held for one bit time
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			serial_in <= fr[i];
			repeat (int'(BIT_CYC) - 1) @(posedge clk);
		end
	endtask

	task automatic recv_byte(output logic [7:0] b);
		int n;
		n = 0;
		while (serial_out !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		repeat (int'(HALF_BIT)) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (int'(BIT_CYC)) @(posedge clk);
			b[i] = serial_out;
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/cpu_status_flags_decimal_alu_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpu_status_flags_decimal_alu_tb
	import cpu_flags_pkg::*;
;
	logic          clk;
	logic          rst_b;
	bus_req_s      bus;
	logic [DW-1:0] rd_data;
	logic          main_osc_input;
	logic          sub_osc_input;
	logic          serial_in;
	logic          serial_shift_clock;
	logic          boot_select_pin;
	logic          serial_out;
	logic          busy_out;
	logic [DW-1:0] port_dir;
	int            n_errors;
	int            checks_done;
	int            t;
	logic [31:0]   seed;
	logic [DW-1:0] a, b, q, hi, p0, p1;
	logic [8:0]    e;
	int            tick_clk[3] = '{8, 32, 20};

	cpu_status_flags_decimal_alu #(.STACK_DEPTH(16)) cpu_status_flags_decimal_alu_inst (
		.clk(clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
		.main_osc_input(main_osc_input), .sub_osc_input(sub_osc_input),
		.boot_select_pin(boot_select_pin), .serial_in(serial_in),
		.serial_shift_clock(serial_shift_clock), .serial_out(serial_out),
		.busy_out(busy_out), .port_dir(port_dir)
	);

	boot_programmer boot_programmer_inst (
		.clk(clk), .serial_out(serial_out), .serial_in(serial_in),
		.serial_shift_clock(serial_shift_clock), .boot_select_pin(boot_select_pin)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Oscillator levels move on clock edges: main 4 clk, sub 10 clk periods
	initial begin
		main_osc_input = 1'b0;
		forever begin
			repeat (2) @(posedge clk);
			main_osc_input <= ~main_osc_input;
		end
	end
	initial begin
		sub_osc_input = 1'b0;
		forever begin
			repeat (5) @(posedge clk);
			sub_osc_input <= ~sub_osc_input;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Two packed decimal digits per byte; bit 8 is the carry flag afterwards
	function automatic logic [8:0] bcd_ref(input logic [7:0] x, y, input logic c, sub);
		int xv, yv, r;
		xv = x[7:4] * 10 + x[3:0];
		yv = y[7:4] * 10 + y[3:0];
		r = sub ? xv - yv - (1 - c) : xv + yv + c;
		bcd_ref[8] = sub ? (r >= 0) : (r > 99);
		r = (r + 100) % 100;
		bcd_ref[7:0] = {4'(r / 10), 4'(r % 10)};
	endfunction

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	task automatic check_near(input string what, input int ex, input int got, input int tol);
		checks_done++;
		if (got < ex - tol || got > ex + tol) begin
			$display("unexpected %s expected %0d seen %0d", what, ex, got);
			n_errors++;
		end
	endtask

	// Request held from one edge to the next; read data stands the cycle after
	task automatic bus_cycle(input logic w, input logic [AW-1:0] ad, input logic [DW-1:0] d,
			output logic [DW-1:0] r);
		@(posedge clk);
		bus <= '{wr: w, rd: ~w, addr: ad, wdata: d};
		@(posedge clk);
		bus <= '0;
		#1 r = rd_data;
	endtask

	task automatic wr(input logic [AW-1:0] ad, input logic [DW-1:0] d);
		logic [DW-1:0] r;
		bus_cycle(1'b1, ad, d, r);
	endtask

	task automatic rd(input logic [AW-1:0] ad, output logic [DW-1:0] r);
		bus_cycle(1'b0, ad, 8'h00, r);
	endtask

	// Returns clock cycles from command to the first read that shows it idle
	task automatic run_op(input opcode_e op, output int el);
		logic [DW-1:0] r;
		// Only package opcodes are issued, then the command register is polled until it reads idle
		wr(ADDR_COMMAND, 8'(op));
		el = 0;
		r = 8'h01;
		while (r[0] !== 1'b0 && el < 2000) begin
			rd(ADDR_COMMAND, r);
			el += 2;
		end
	endtask

	// Push leaves the status word one place above the stack pointer
	task automatic get_psw(output logic [DW-1:0] ps);
		int el;
		run_op(OP_PUSH_PSW, el);
		rd(ADDR_STACK_TOP, ps);
		wr(ADDR_STACK_PTR, 8'hff);
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		final_report();
	end

	initial begin
		bus = '0;
		rst_b = 1'b0;
		n_errors = 0;
		checks_done = 0;
		seed = 32'h655070cb;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		run_op(OP_PUSH_PSW, t);
		rd(ADDR_STACK_PTR, q);
		check("stack pointer", 16'h00fe, {8'h00, q});
		rd(ADDR_STACK_TOP, q);
		check("interrupt mask", 16'h0001, {15'h0, q[FLG_I]});
		wr(ADDR_STACK_PTR, 8'hff);
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_CLOCK_MODE, 8'(m));
			run_op(OP_PRODUCT, t);
			check_near("product time", 8 * tick_clk[m], t, tick_clk[m] + 4);
		end
		wr(ADDR_CLOCK_MODE, 8'(CLK_HIGH));
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			a = {4'(seed[7:4] % 10), 4'(seed[3:0] % 10)};
			b = {4'(seed[15:12] % 10), 4'(seed[11:8] % 10)};
			if (i < 2) begin
				a = i[0] ? 8'h00 : 8'h99;
				b = i[0] ? 8'h01 : 8'h99;
			end
			run_op(OP_SET_D, t);
			run_op(i[0] ? OP_SET_C : OP_CLR_C, t);
			wr(ADDR_OPERAND_A, a);
			wr(ADDR_OPERAND_B, b);
			run_op(i[0] ? OP_SUBB : OP_ADDC, t);
			check_near("arith time", 16, t, 12);
			e = bcd_ref(a, b, i[0], i[0]);
			rd(ADDR_RESULT_LO, q);
			check("decimal result", {8'h00, e[7:0]}, {8'h00, q});
			// The push is the other instruction needed before carry or mode changes
			get_psw(p0);
			// Sign, overflow and zero carry no meaning here, so only C and D are compared
			check("decimal carry", {15'h0, e[8]}, {15'h0, p0[FLG_C]});
			check("decimal mode", 16'h0001, {15'h0, p0[FLG_D]});
		end
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			a = seed[7:0];
			b = (i == 5) ? 8'h00 : seed[15:8];
			run_op(i[0] ? OP_SET_D : OP_CLR_D, t);
			run_op(i[1] ? OP_SET_C : OP_CLR_C, t);
			get_psw(p0);
			wr(ADDR_OPERAND_A, a);
			wr(ADDR_OPERAND_B, b);
			run_op(OP_PRODUCT, t);
			rd(ADDR_RESULT_LO, q);
			rd(ADDR_RESULT_HI, hi);
			check("product", 16'(a) * 16'(b), {hi, q});
			run_op(OP_QUOTIENT, t);
			check_near("quotient time", 128, t, 12);
			rd(ADDR_RESULT_LO, q);
			rd(ADDR_RESULT_HI, hi);
			check("quotient", (b == 0) ? {a, 8'hff} : {a % b, a / b}, {hi, q});
			get_psw(p1);
			check("status kept", {8'h00, p0}, {8'h00, p1});
		end
		// Pull must bring back the pushed carry after it was cleared
		run_op(OP_SET_C, t);
		run_op(OP_PUSH_PSW, t);
		run_op(OP_CLR_C, t);
		run_op(OP_PULL_PSW, t);
		rd(ADDR_STACK_PTR, q);
		check("pulled pointer", 16'h00ff, {8'h00, q});
		get_psw(p1);
		check("pulled carry", 16'h0001, {15'h0, p1[FLG_C]});
		// Increment stays binary even with the decimal flag set
		run_op(OP_SET_D, t);
		wr(ADDR_OPERAND_A, 8'h09);
		run_op(OP_INCR, t);
		rd(ADDR_RESULT_LO, q);
		check("plain increment", 16'h000a, {8'h00, q});
		seed = lfsr(seed);
		wr(ADDR_PORT_DIR, seed[7:0]);
		check("port direction", {8'h00, seed[7:0]}, {8'h00, port_dir});
		rd(ADDR_PORT_DIR, q);
		check("direction readback", 16'h0000, {8'h00, q});
		rd(4'h3, q);
		check("unmapped read", 16'h0000, {8'h00, q});
		boot_programmer_inst.enter_boot();
		rst_b <= 1'b0;
		repeat (64) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_BOOT_STAT, q);
		check("boot active", 16'h0001, {15'h0, q[BST_ACTIVE]});
		boot_programmer_inst.sclk_glitch();
		rd(ADDR_BOOT_STAT, q);
		check("shift clock fault", 16'h0001, {15'h0, q[BST_SCLK]});
		wr(ADDR_BOOT_STAT, 8'h02);
		rd(ADDR_BOOT_STAT, q);
		check("fault cleared", 16'h0000, {15'h0, q[BST_SCLK]});
		for (int k = 0; k < 2; k++) begin
			seed = lfsr(seed);
			a = (k == 0) ? 8'h80 : seed[7:0];
			check("idle serial out", 16'h0001, {15'h0, serial_out});
			fork
				boot_programmer_inst.send_byte(a);
				boot_programmer_inst.recv_byte(b);
				begin
					repeat (20) @(posedge clk);
					check("busy", 16'h0001, {15'h0, busy_out});
				end
			join
			check("echo byte", {8'h00, a}, {8'h00, b});
			t = 0;
			while (busy_out !== 1'b0 && t < 2000) begin
				@(posedge clk);
				t++;
			end
			rd(ADDR_BOOT_RX, q);
			check("received byte", {8'h00, a}, {8'h00, q});
			rd(ADDR_BOOT_STAT, q);
			check("byte taken", 16'h0000, {15'h0, q[BST_RXV]});
		end
		final_report();
	end
endmodule
`default_nettype wire
